//--- src/dual_timer_consts.svh
// Constants for the dual four-mode timer: counts, widths, reset values.
// Assumes inclusion by bare name from files that need the timing figures.
//
// Contract
// - Two-bit mode picks one of four modes; mode 1 is a full 16-bit timer.
// - Mode 0 is an 8-bit counter behind a divide-by-32 prescaler.
// - Mode 2 is 8-bit, reloading from a separate reload value on overflow.
// - Mode 3 splits timer 0 into two 8-bit timers; timer 1 stops.
// - Counting advances once per machine cycle of twelve clock periods.
// - Software may let a gate input bound counting for pulse-width measurement.
`ifndef DUAL_TIMER_CONSTS_SVH
`define DUAL_TIMER_CONSTS_SVH

// ==========================================================
// Clock and machine cycle
`define CLK_PERIOD_NS   20
`define MCYCLE_CLKS     12
`define MCYCLE_LAST     4'hB
`define MCYCLE_W        4

// ==========================================================
// Counter layout
`define COUNT_W         16
`define BYTE_W          8
`define PRESCALE_DIV    32
`define PRESCALE_W      5
`define MODE0_W         13
`define COUNT_RESET     16'h0000
`define BYTE_MAX        8'hFF
`define MODE0_MAX       13'h1FFF
`define FULL_MAX        16'hFFFF
`define PRESCALE_MAX    5'h1F

`endif

//--- src/dual_timer_pkg.sv
// Types shared by the dual four-mode timer.
// Assumes the constants header is available alongside.
package dual_timer_pkg;

  // ==========================================================
  // Operating modes, in mode-field order
  typedef enum logic [1:0] {
    MODE_PRESCALED,
    MODE_FULL16,
    MODE_RELOAD8,
    MODE_SPLIT
  } timer_mode_t;

endpackage

//--- src/dual_timer_four_mode.sv
// Two general-purpose timers with four modes each, counted per machine cycle.
// Assumes all control inputs are synchronous to ref_clk_i and held by software.
`timescale 1ns/1ps
`include "dual_timer_consts.svh"

module dual_timer_four_mode (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [1:0]  mode_select0_i,
  input  wire logic [1:0]  mode_select1_i,
  input  wire logic        run0_i,
  input  wire logic        run1_i,
  input  wire logic        gate_enable0_i,
  input  wire logic        gate_enable1_i,
  input  wire logic        gate_input_a_i,
  input  wire logic        gate_input_b_i,
  input  wire logic [7:0]  reload0_i,
  input  wire logic [7:0]  reload1_i,
  input  wire logic        clear_flag0_i,
  input  wire logic        clear_flag1_i,
  output logic      [15:0] count0_o,
  output logic      [15:0] count1_o,
  output logic             overflow0_o,
  output logic             overflow1_o
);

  // ==========================================================
  // Machine cycle divider
  logic [`MCYCLE_W-1:0] mcycle_reg;
  logic [`MCYCLE_W-1:0] mcycle_next;
  logic                 tick;

  assign tick        = (mcycle_reg == `MCYCLE_LAST);
  assign mcycle_next = tick ? '0 : mcycle_reg + 4'h1;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mcycle_reg <= '0;
    end else begin
      mcycle_reg <= mcycle_next;
    end
  end

  // ==========================================================
  // Per-timer control decode
  dual_timer_pkg::timer_mode_t mode [0:1];
  logic [`COUNT_W-1:0]         count_reg  [0:1];
  logic [`COUNT_W-1:0]         count_next [0:1];
  logic [`BYTE_W-1:0]          reload     [0:1];
  logic [1:0]                  run;
  logic [1:0]                  gate_en;
  logic [1:0]                  gate_in;
  logic [1:0]                  count_en;
  logic [1:0]                  wrap;
  logic                        split_hi_en;
  logic                        split_hi_wrap;

  assign mode[0]   = dual_timer_pkg::timer_mode_t'(mode_select0_i);
  assign mode[1]   = dual_timer_pkg::timer_mode_t'(mode_select1_i);
  assign reload[0] = reload0_i;
  assign reload[1] = reload1_i;
  assign run       = {run1_i, run0_i};
  assign gate_en   = {gate_enable1_i, gate_enable0_i};
  assign gate_in   = {gate_input_b_i, gate_input_a_i};

  // Split mode borrows timer 1's run bit for timer 0's upper byte, ungated
  assign split_hi_en = tick && run1_i && (mode[0] == dual_timer_pkg::MODE_SPLIT);

  // ==========================================================
  // Counting logic, one copy per timer
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_timer
      logic [`MODE0_W-1:0] low13;
      logic                split_stop;

      // Gate input holds the count while low, when gating is enabled
      assign count_en[i] = tick && run[i] && (!gate_en[i] || gate_in[i]);
      // Timer 1 freezes in split mode
      assign split_stop  = (i == 1) && (mode[i] == dual_timer_pkg::MODE_SPLIT);
      assign low13       = count_reg[i][`MODE0_W-1:0];

      always_comb begin
        count_next[i] = count_reg[i];
        wrap[i]       = 1'b0;
        if (count_en[i] && !split_stop) begin
          unique case (mode[i])
            // Low five bits are the divide-by-32 prescaler
            dual_timer_pkg::MODE_PRESCALED: begin
              count_next[i][`MODE0_W-1:0] = low13 + 13'h0001;
              wrap[i] = (low13 == `MODE0_MAX);
            end
            dual_timer_pkg::MODE_FULL16: begin
              count_next[i] = count_reg[i] + 16'h0001;
              wrap[i] = (count_reg[i] == `FULL_MAX);
            end
            // Reload low byte from reload value on overflow
            dual_timer_pkg::MODE_RELOAD8: begin
              wrap[i] = (count_reg[i][7:0] == `BYTE_MAX);
              count_next[i][7:0] = wrap[i] ? reload[i] : count_reg[i][7:0] + 8'h01;
            end
            // Timer 0 low byte as its own 8-bit timer
            dual_timer_pkg::MODE_SPLIT: begin
              count_next[i][7:0] = count_reg[i][7:0] + 8'h01;
              wrap[i] = (count_reg[i][7:0] == `BYTE_MAX);
            end
          endcase
        end
        // Timer 0 upper byte as the second 8-bit timer
        if ((i == 0) && split_hi_en) begin
          count_next[i][15:8] = count_reg[i][15:8] + 8'h01;
        end
      end

      always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          count_reg[i] <= `COUNT_RESET;
        end else begin
          count_reg[i] <= count_next[i];
        end
      end
    end
  endgenerate

  assign split_hi_wrap = split_hi_en && (count_reg[0][15:8] == `BYTE_MAX);

  // ==========================================================
  // Overflow flags
  // Set beats clear, so an overflow in the clearing cycle is never lost
  logic flag0_next;
  logic flag1_next;
  logic flag1_set;

  // Roll-over sets the flag; split upper byte reports through flag 1
  assign flag1_set  = wrap[1] || split_hi_wrap;
  assign flag0_next = wrap[0] || (overflow0_o && !clear_flag0_i);
  assign flag1_next = flag1_set || (overflow1_o && !clear_flag1_i);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      overflow0_o <= 1'b0;
      overflow1_o <= 1'b0;
    end else begin
      overflow0_o <= flag0_next;
      overflow1_o <= flag1_next;
    end
  end

  assign count0_o = count_reg[0];
  assign count1_o = count_reg[1];

  // ==========================================================
  // Checks
  sequence s_reload_wrap;
    tick && run0_i && !gate_enable0_i && (mode[0] == dual_timer_pkg::MODE_RELOAD8)
      && (count0_o[7:0] == `BYTE_MAX);
  endsequence

  sequence s_reload_done;
    (count0_o[7:0] == $past(reload0_i)) && overflow0_o;
  endsequence

  a_machine_tick_spacing: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    tick |=> !tick [*8] ##1 !tick [*3] ##1 tick)
    else $error("machine cycle tick not every twelve clocks");

  a_full16_step: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (count_en[0] && mode[0] == dual_timer_pkg::MODE_FULL16)
      |=> count0_o == $past(count0_o) + 16'h0001)
    else $error("16-bit mode did not step by one");

  a_prescale_hold: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (count_en[0] && mode[0] == dual_timer_pkg::MODE_PRESCALED
      && count0_o[`PRESCALE_W-1:0] != `PRESCALE_MAX)
      |=> count0_o[12:5] == $past(count0_o[12:5]))
    else $error("prescaled count advanced before 32 steps");

  a_reload_value: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    s_reload_wrap |=> s_reload_done)
    else $error("auto-reload did not load reload value and flag");

  a_split_stops_t1: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (mode[1] == dual_timer_pkg::MODE_SPLIT) |=> $stable(count1_o))
    else $error("timer 1 counted in split mode");

  a_gate_blocks: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (gate_enable1_i && !gate_input_b_i && mode[0] != dual_timer_pkg::MODE_SPLIT)
      |=> $stable(count1_o))
    else $error("timer 1 counted while gate input low");

  // A full 16-bit roll-over takes far too long to reach, so byte roll-overs carry the flag checks
  a_overflow_flag: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (count_en[0] && mode[0] == dual_timer_pkg::MODE_SPLIT && count0_o[7:0] == `BYTE_MAX)
      |=> (count0_o[7:0] == 8'h00) && overflow0_o)
    else $error("low byte roll-over did not set overflow flag 0");

  a_split_high_flag: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (split_hi_en && count0_o[15:8] == `BYTE_MAX)
      |=> (count0_o[15:8] == 8'h00) && overflow1_o)
    else $error("upper byte roll-over did not set overflow flag 1");

  a_flag0_cleared: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (overflow0_o && clear_flag0_i && !wrap[0]) |=> !overflow0_o)
    else $error("overflow flag 0 did not clear");

  a_split_high_step: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    split_hi_en |=> count0_o[15:8] == $past(count0_o[15:8]) + 8'h01)
    else $error("split upper byte did not step by one");

  a_reload_upper_hold: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (mode[0] == dual_timer_pkg::MODE_RELOAD8) |=> $stable(count0_o[15:8]))
    else $error("reload mode disturbed the upper byte");

  a_gate_blocks_t0: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (gate_enable0_i && !gate_input_a_i) |=> $stable(count0_o[7:0]))
    else $error("timer 0 counted while gate input low");

endmodule

//--- tb/tb_dual_timer_four_mode.sv
// Testbench for the dual four-mode timer: one hand-written task per scenario.
// Assumes one count step per twelve clocks, first step at the 12th edge after reset.
`timescale 1ns/1ps
module tb_dual_timer_four_mode;
  // ==========================================================
  // Stimulus and observed signals
  logic        ref_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [1:0]  mode_select0_i = 2'h1;
  logic [1:0]  mode_select1_i = 2'h1;
  logic        run0_i = 1'b0, run1_i = 1'b0;
  logic        gate_enable0_i = 1'b0, gate_enable1_i = 1'b0;
  logic        gate_input_a_i = 1'b0, gate_input_b_i = 1'b0;
  logic [7:0]  reload0_i = 8'h00, reload1_i = 8'h00;
  logic        clear_flag0_i = 1'b0, clear_flag1_i = 1'b0;
  logic [15:0] count0_o, count1_o;
  logic        overflow0_o, overflow1_o;
  int          error_cnt = 0;
  int          check_count = 0;

  dual_timer_four_mode dut (.ref_clk_i, .nrst_i, .mode_select0_i, .mode_select1_i,
    .run0_i, .run1_i, .gate_enable0_i, .gate_enable1_i, .gate_input_a_i,
    .gate_input_b_i, .reload0_i, .reload1_i, .clear_flag0_i, .clear_flag1_i,
    .count0_o, .count1_o, .overflow0_o, .overflow1_o);

  always #10 ref_clk_i = ~ref_clk_i;

  // ==========================================================
  // Shared helpers
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Sampling six edges away from any tick keeps checks clear of update edges
  task automatic restart;
    nrst_i <= 1'b0;
    @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    chk16(count0_o, 16'h0000);
    chk1(overflow0_o, 1'b0);
    nrst_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
  endtask
  task automatic mc(input int n);
    repeat (12 * n) @(posedge ref_clk_i);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_full;
    mode_select0_i <= 2'h1;
    mode_select1_i <= 2'h1;
    run0_i <= 1'b1;
    run1_i <= 1'b0;
    restart;
    mc(3);
    chk16(count0_o, 16'h0003);
    chk16(count1_o, 16'h0000);
    $display("test full16 done");
  endtask
  task automatic t_prescale;
    mode_select0_i <= 2'h0;
    restart;
    mc(40);
    chk16(count0_o, 16'h0028);
    $display("test prescaled done");
  endtask
  task automatic t_reload;
    mode_select0_i <= 2'h2;
    mode_select1_i <= 2'h2;
    reload0_i <= 8'hFD;
    reload1_i <= 8'h80;
    run1_i <= 1'b1;
    restart;
    mc(255);
    chk16(count0_o, 16'h00FF);
    chk1(overflow0_o, 1'b0);
    mc(1);
    chk16(count0_o, 16'h00FD);
    chk16(count1_o, 16'h0080);
    chk1(overflow0_o, 1'b1);
    chk1(overflow1_o, 1'b1);
    mc(3);
    chk16(count0_o, 16'h00FD);
    clear_flag0_i <= 1'b1;
    @(posedge ref_clk_i);
    clear_flag0_i <= 1'b0;
    mc(1);
    chk1(overflow0_o, 1'b0);
    chk1(overflow1_o, 1'b1);
    $display("test reload8 done");
  endtask
  task automatic t_split;
    mode_select0_i <= 2'h3;
    mode_select1_i <= 2'h3;
    restart;
    mc(3);
    chk16(count0_o, 16'h0303);
    chk16(count1_o, 16'h0000);
    run0_i <= 1'b0;
    mc(2);
    chk16(count0_o, 16'h0503);
    $display("test split done");
  endtask
  task automatic t_split_wrap;
    mode_select0_i <= 2'h3;
    mode_select1_i <= 2'h3;
    run0_i <= 1'b1;
    run1_i <= 1'b1;
    restart;
    mc(255);
    chk16(count0_o, 16'hFFFF);
    chk1(overflow0_o, 1'b0);
    chk1(overflow1_o, 1'b0);
    // Clear lands on the roll-over edge itself, so the set must win
    repeat (5) @(posedge ref_clk_i);
    clear_flag0_i <= 1'b1;
    clear_flag1_i <= 1'b1;
    @(posedge ref_clk_i);
    clear_flag0_i <= 1'b0;
    clear_flag1_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    chk16(count0_o, 16'h0000);
    chk16(count1_o, 16'h0000);
    chk1(overflow0_o, 1'b1);
    chk1(overflow1_o, 1'b1);
    $display("test split wrap done");
  endtask
  task automatic t_gate;
    mode_select0_i <= 2'h1;
    mode_select1_i <= 2'h1;
    run0_i <= 1'b1;
    gate_enable0_i <= 1'b1;
    gate_enable1_i <= 1'b1;
    gate_input_b_i <= 1'b1;
    restart;
    mc(3);
    chk16(count0_o, 16'h0000);
    gate_input_a_i <= 1'b1;
    gate_input_b_i <= 1'b0;
    mc(2);
    chk16(count0_o, 16'h0002);
    chk16(count1_o, 16'h0003);
    $display("test gate done");
  endtask

  // ==========================================================
  // Sequence and verdict
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge ref_clk_i);
    t_full;
    t_prescale;
    t_reload;
    t_split;
    t_split_wrap;
    t_gate;
    stop_test;
  end
endmodule
